// ===== common/iatpc_consts.vh
// constants for the isolated adc trim, converter and checksum register bank
`ifndef IATPC_CONSTS_VH
`define IATPC_CONSTS_VH
`define IATPC_ADDR_GAIN_HIGH    6'h0c
`define IATPC_ADDR_GAIN_LOW     6'h0d
`define IATPC_ADDR_CONV_CTRL    6'h31
`define IATPC_ADDR_CHECKSUM     6'h3e
`define IATPC_RST_GAIN_HIGH     16'h8000
`define IATPC_RST_GAIN_LOW      16'h0000
`define IATPC_RST_CONV_CTRL     16'h0000
`define IATPC_RST_CHECKSUM      16'h0000
`define IATPC_RST_GAIN_BYTE     8'h00
`define IATPC_LAST_BIT          5'h17
`define IATPC_FREQ_MSB          11
`define IATPC_FREQ_LSB          8
`define IATPC_ENABLE_BIT        0
`define IATPC_GAIN_LOW_MASK     16'hff00
`define IATPC_CONV_CTRL_MASK    16'h0f01
`define IATPC_CRC_POLY          16'h1021
`define IATPC_CRC_SEED          16'hffff
`define IATPC_CMD_READ          1'b1
`endif

// ===== hdl/iatpc_crc16.v
// serial crc-16 engine over a sequence of 16-bit words, one word per cycle
`timescale 1ns/10ps
`default_nettype none
`include "iatpc_consts.vh"
module iatpc_crc16 (
  // clock and reset
  input  wire        mclk_i,
  input  wire        rst_i,
  // control
  input  wire        start_i,
  input  wire        word_valid_i,
  input  wire [15:0] word_i,
  // result
  output wire [15:0] crc_o
);
  reg  [15:0] crc_reg;
  reg  [15:0] crc_next;
  integer     k;

  // fold one 16-bit word, msb first
  always @* begin
    crc_next = start_i ? `IATPC_CRC_SEED : crc_reg;
    if (word_valid_i) begin
      for (k = 15; k >= 0; k = k - 1) begin
        if (crc_next[15] ^ word_i[k])
          crc_next = {crc_next[14:0], 1'b0} ^ `IATPC_CRC_POLY;
        else
          crc_next = {crc_next[14:0], 1'b0};
      end
    end
  end

  always @(posedge mclk_i) begin
    if (rst_i)
      crc_reg <= `IATPC_CRC_SEED;
    else
      crc_reg <= crc_next;
  end

  assign crc_o = crc_reg;
endmodule // iatpc_crc16
`default_nettype wire

// ===== hdl/iatpc_regs.v
// register bank: gain trim, isolated converter control, register-map checksum
// Behaviour
// RULE_01: gain bits 7..0 live in low trim bits 15..8; low byte reads zero.
// RULE_02: gain bits 23..8 come from the high gain trim register.
// RULE_03: frequency range field bits 11..8 picks modulator band; 0000 is highest.
// RULE_04: converter control bit 0 enables isolated converter; resets off.
// RULE_05: checksum register presents 16-bit crc of register map, resets zero.
// RULE_06: host may tie chip select low only as sole bus peripheral.
// RULE_07: with chip select tied low host enables both data checksums; the 24-bit frames here carry no checksum.
// RULE_08: with chip select tied low host clocks every word of reads.
// RULE_09: host connects sync reset or sample ready to stay aligned.
// RULE_10: host may count master clocks instead; bit errors then unrecoverable.
// RULE_11: unused sync reset input is held high by the host board.
// RULE_12: checksum recomputed after every register write.
`timescale 1ns/10ps
`default_nettype none
`include "iatpc_consts.vh"
module iatpc_regs (
  // clock and reset
  input  wire        mclk_i,
  input  wire        rst_i,
  // spi pins, asynchronous to mclk_i
  input  wire        spi_sclk_i,
  input  wire        spi_cs_n_i,
  input  wire        spi_mosi_i,
  output wire        spi_miso_o,
  output wire        spi_miso_oe_o,
  // fields to the analog side
  output wire [23:0] gain_factor_o,
  output wire [3:0]  converter_freq_range_o,
  output wire        converter_enable_o
);
  // frame: 24-bit word in, bit23 read flag, bits 21:16 address, 15:0 data
  localparam ST_IDLE = 2'b00;
  localparam ST_CRC  = 2'b01;
  localparam ST_DONE = 2'b10;

  // pin synchronisers; the third sclk stage only feeds edge detection
  reg  [2:0]  sclk_sync_reg;
  reg  [1:0]  cs_sync_reg;
  reg  [1:0]  mosi_sync_reg;

  // programmable registers and the checksum result
  reg  [15:0] gain_high_reg;
  reg  [7:0]  gain_low_byte_reg;
  reg  [15:0] conv_ctrl_reg;
  reg  [15:0] checksum_reg;

  // serial framing
  reg  [23:0] shift_in_reg;
  reg  [4:0]  bit_cnt_reg;
  reg  [15:0] shift_out_reg;
  reg         miso_reg;
  reg         miso_oe_reg;

  // checksum sequencing
  reg  [1:0]  crc_state_reg;
  reg  [1:0]  crc_idx_reg;
  reg         crc_pend_reg;
  reg  [15:0] crc_word;
  wire        crc_start;
  wire        crc_step;
  wire [15:0] crc_val;

  // decoded frame
  reg  [15:0] rd_data;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_active;
  wire [23:0] word_done;
  wire        word_end;
  wire        is_read;
  wire        wr_hit;
  wire [5:0]  addr;

  // sclk: two settling stages plus one for edge detection
  always @(posedge mclk_i) begin
    if (rst_i)
      sclk_sync_reg <= 3'h0; // idle low, so no false rise after reset
    else
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk_i};
  end

  // chip select resets to its released level
  always @(posedge mclk_i) begin
    if (rst_i)
      cs_sync_reg <= 2'h3;
    else
      cs_sync_reg <= {cs_sync_reg[0], spi_cs_n_i};
  end

  // host data, same latency as the settled sclk stage
  always @(posedge mclk_i) begin
    if (rst_i)
      mosi_sync_reg <= 2'h0;
    else
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi_i};
  end

  // edges and frame decode from the settled stages only
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign cs_active = ~cs_sync_reg[1];
  assign word_done = {shift_in_reg[22:0], mosi_sync_reg[1]};
  assign word_end  = cs_active & sclk_rise & (bit_cnt_reg == `IATPC_LAST_BIT);
  assign is_read   = word_done[23] == `IATPC_CMD_READ;
  assign wr_hit    = word_end & ~is_read;
  assign addr      = word_done[21:16];

  // read mux; unmapped addresses return zero
  always @* begin
    case (addr)
      `IATPC_ADDR_GAIN_HIGH: rd_data = gain_high_reg;
      `IATPC_ADDR_GAIN_LOW:  rd_data = {gain_low_byte_reg, 8'h00}; // see RULE_01
      `IATPC_ADDR_CONV_CTRL: rd_data = conv_ctrl_reg;
      `IATPC_ADDR_CHECKSUM:  rd_data = checksum_reg; // see RULE_05
      default:               rd_data = 16'h0000;
    endcase
  end

  // serial shifter; a tied-low chip select works as long as words stay aligned
  always @(posedge mclk_i) begin
    if (rst_i) begin
      shift_in_reg  <= 24'h000000;
      bit_cnt_reg   <= 5'h00;
      shift_out_reg <= 16'h0000;
      miso_reg      <= 1'b0;
      miso_oe_reg   <= 1'b0;
    end else begin
      miso_oe_reg <= cs_active;
      if (!cs_active) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise) begin
        shift_in_reg <= word_done;
        bit_cnt_reg  <= (bit_cnt_reg == `IATPC_LAST_BIT) ? 5'h00 : bit_cnt_reg + 5'h01;
        if (word_end)
          shift_out_reg <= is_read ? rd_data : 16'h0000;
      end else if (sclk_fall) begin
        miso_reg      <= shift_out_reg[15];
        shift_out_reg <= {shift_out_reg[14:0], 1'b0};
      end
    end
  end

  // register writes
  always @(posedge mclk_i) begin
    if (rst_i) begin
      gain_high_reg     <= `IATPC_RST_GAIN_HIGH;
      gain_low_byte_reg <= `IATPC_RST_GAIN_BYTE;
      conv_ctrl_reg     <= `IATPC_RST_CONV_CTRL; // see RULE_04
    end else if (wr_hit) begin
      case (addr)
        `IATPC_ADDR_GAIN_HIGH: gain_high_reg     <= word_done[15:0]; // see RULE_02
        `IATPC_ADDR_GAIN_LOW:  gain_low_byte_reg <= word_done[15:8]; // see RULE_01
        `IATPC_ADDR_CONV_CTRL: conv_ctrl_reg     <= word_done[15:0] & `IATPC_CONV_CTRL_MASK; // see RULE_03
        default: ;
      endcase
    end
  end

  // checksum walk over the three writable registers after each write
  always @* begin
    case (crc_idx_reg)
      2'h0:    crc_word = gain_high_reg;
      2'h1:    crc_word = {gain_low_byte_reg, 8'h00};
      default: crc_word = conv_ctrl_reg;
    endcase
  end

  // recompute request; a write in the pickup cycle wins over the clear
  always @(posedge mclk_i) begin
    if (rst_i)
      crc_pend_reg <= 1'b0;
    else if (wr_hit)
      crc_pend_reg <= 1'b1; // see RULE_12
    else if ((crc_state_reg == ST_IDLE) && crc_pend_reg)
      crc_pend_reg <= 1'b0;
  end

  // three-word walk, then latch the result
  always @(posedge mclk_i) begin
    if (rst_i) begin
      crc_state_reg <= ST_IDLE;
      crc_idx_reg   <= 2'h0;
      checksum_reg  <= `IATPC_RST_CHECKSUM;
    end else begin
      case (crc_state_reg)
        ST_IDLE: begin
          if (crc_pend_reg) begin
            crc_idx_reg   <= 2'h0;
            crc_state_reg <= ST_CRC;
          end
        end
        ST_CRC: begin
          crc_idx_reg <= crc_idx_reg + 2'h1;
          if (crc_idx_reg == 2'h2)
            crc_state_reg <= ST_DONE;
        end
        ST_DONE: begin
          checksum_reg  <= crc_val; // see RULE_05
          crc_state_reg <= ST_IDLE;
        end
        default: crc_state_reg <= ST_IDLE;
      endcase
    end
  end

  // the engine seeds itself on the first word of the walk
  assign crc_start = (crc_state_reg == ST_CRC) && (crc_idx_reg == 2'h0);
  assign crc_step  = (crc_state_reg == ST_CRC);

  iatpc_crc16 u_crc (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .start_i      (crc_start),
    .word_valid_i (crc_step),
    .word_i       (crc_word),
    .crc_o        (crc_val)
  );

  assign spi_miso_o             = miso_reg;
  assign spi_miso_oe_o          = miso_oe_reg;
  assign gain_factor_o          = {gain_high_reg, gain_low_byte_reg}; // see RULE_02
  assign converter_freq_range_o = conv_ctrl_reg[`IATPC_FREQ_MSB:`IATPC_FREQ_LSB]; // see RULE_03
  assign converter_enable_o     = conv_ctrl_reg[`IATPC_ENABLE_BIT]; // see RULE_04
endmodule // iatpc_regs
`default_nettype wire

// ===== test/iatpc_monitor.sv
// port checker for the trim, converter and checksum register bank
`timescale 1ns/10ps
`default_nettype none
module iatpc_monitor (
  // clock, reset, link clock and chip select
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        spi_sclk_i,
  input wire logic        spi_cs_n_i,
  // output enable and fields to the analog side
  input wire logic        spi_miso_oe_o,
  input wire logic [23:0] gain_factor_o,
  input wire logic [3:0]  converter_freq_range_o,
  input wire logic        converter_enable_o
);
  logic [4:0] since_rise_reg;
  logic       sclk_q_reg;
  // cycles since the last sclk rise, saturating
  always_ff @(posedge mclk_i) begin
    sclk_q_reg <= spi_sclk_i;
    if (rst_i || (spi_sclk_i && !sclk_q_reg)) since_rise_reg <= rst_i ? 5'h1f : 5'h00;
    else if (since_rise_reg != 5'h1f) since_rise_reg <= since_rise_reg + 5'h01;
  end
  chk_gain_reset: assert property (@(posedge mclk_i) rst_i |=> gain_factor_o == 24'h800000)
    else $error("gain factor not at reset value");
  chk_conv_reset: assert property (@(posedge mclk_i) rst_i |=> !converter_enable_o && converter_freq_range_o == 4'h0)
    else $error("converter fields not at reset value");
  chk_gain_hold: assert property (@(posedge mclk_i) disable iff (rst_i) since_rise_reg > 5'h0e |-> $stable(gain_factor_o))
    else $error("gain factor moved without a word");
  chk_conv_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    since_rise_reg > 5'h0e |-> $stable({converter_freq_range_o, converter_enable_o}))
    else $error("converter fields moved without a word");
  chk_oe_release: assert property (@(posedge mclk_i) disable iff (rst_i)
    spi_cs_n_i [*5] |=> !spi_miso_oe_o)
    else $error("output enable high with chip select released");
  chk_oe_drive: assert property (@(posedge mclk_i) disable iff (rst_i)
    !spi_cs_n_i [*5] |=> spi_miso_oe_o)
    else $error("output enable low with chip select held");
endmodule // iatpc_monitor
bind iatpc_regs iatpc_monitor u_mon (.mclk_i(mclk_i), .rst_i(rst_i), .spi_sclk_i(spi_sclk_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_miso_oe_o(spi_miso_oe_o), .gain_factor_o(gain_factor_o),
  .converter_freq_range_o(converter_freq_range_o), .converter_enable_o(converter_enable_o));
`default_nettype wire

// ===== test/iatpc_host_model.sv
// spi host model clocking whole 24-bit words, mode 0
`timescale 1ns/10ps
`default_nettype none
module iatpc_host_model (
  // clock
  input  wire logic        mclk_i,
  // spi pins
  output var  logic        spi_sclk_o,
  output var  logic        spi_cs_n_o,
  output var  logic        spi_mosi_o,
  input  wire logic        spi_miso_i,
  input  wire logic        spi_miso_oe_i,
  // captured answer
  output var  logic [15:0] rd_data_o,
  output var  logic        rd_stb_o
);
  logic [23:0] cap_q = 24'h000000;
  // released line shows the inverse of the last bit
  wire         miso_w = spi_miso_oe_i ? spi_miso_i : ~cap_q[0];
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
    rd_data_o = 16'h0000;
    rd_stb_o = 1'b0;
  end
  // every bit of every word clocked, 160 ns period
  task automatic xfer(input logic [23:0] w, input bit cap);
    for (int i = 23; i >= 0; i--) begin
      @(posedge mclk_i) spi_cs_n_o <= 1'b0; // sole device, held low
      spi_mosi_o <= w[i];
      repeat (9) @(posedge mclk_i); // phases counted in mclk periods
      spi_sclk_o <= 1'b1;
      cap_q <= {cap_q[22:0], miso_w};
      repeat (10) @(posedge mclk_i);
      spi_sclk_o <= 1'b0;
    end
    rd_data_o <= cap_q[23:8];
    rd_stb_o <= cap;
    @(posedge mclk_i) rd_stb_o <= 1'b0;
  endtask
endmodule // iatpc_host_model
`default_nettype wire

// ===== test/isolated_adc_trim_power_crc_regs_bench.sv
// bench for the trim, converter and checksum register bank
`timescale 1ns/10ps
`default_nettype none
module isolated_adc_trim_power_crc_regs_bench;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  wire         sclk, cs_n, mosi, miso, miso_oe, stb, en;
  wire  [15:0] rd;
  wire  [23:0] gain;
  wire  [3:0]  freq;
  int          fail_count = 0;
  int          compares = 0;
  logic [15:0] exp_q[$];
  logic [15:0] regs[3];
  logic [15:0] v;
  always #4 mclk_i = ~mclk_i;
  iatpc_regs u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .gain_factor_o(gain), .converter_freq_range_o(freq),
    .converter_enable_o(en));
  iatpc_host_model u_host (.mclk_i(mclk_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
    .spi_miso_i(miso), .spi_miso_oe_i(miso_oe), .rd_data_o(rd), .rd_stb_o(stb));
  task automatic cmp_out(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [15:0] got, input logic [15:0] exp);
    cmp_out({8'h00, got}, {8'h00, exp});
  endtask
  task automatic end_of_test();
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bitwise crc over gain high, gain low, control
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    c = 16'hffff;
    for (int w = 0; w < 3; w++)
      for (int b = 15; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ regs[w][b]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // write word, with the register model kept alongside
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    u_host.xfer({2'b00, a, d}, 1'b0);
    if (a == 6'h0c) regs[0] = d;
    if (a == 6'h0d) regs[1] = d & 16'hff00;
    if (a == 6'h31) regs[2] = d & 16'h0f01;
  endtask
  // read word, answer carried by a following unmapped read
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
    u_host.xfer({2'b10, a, 16'h0000}, 1'b0);
    exp_q.push_back(e);
    u_host.xfer(24'hbf0000, 1'b1);
  endtask
  // watcher pairing each answer with the oldest note
  always @(posedge mclk_i) if (stb === 1'b1) cmp_rd(rd, exp_q.pop_front());
  initial begin
    repeat (70000) @(posedge mclk_i);
    fail_count++;
    end_of_test();
  end
  initial begin
    v = $urandom(59);
    regs = '{16'h8000, 16'h0000, 16'h0000};
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0; // host timing starts from this release
    repeat (4) @(negedge mclk_i);
    cmp_out(gain, 24'h800000);
    cmp_out({19'h0, freq, en}, 24'h000000);
    rd_chk(6'h3e, 16'h0000);
    rd_chk(6'h0c, 16'h8000);
    rd_chk(6'h3f, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      wr(6'h0c, 16'($urandom));
      wr(6'h0d, 16'($urandom));
      v = 16'($urandom);
      wr(6'h31, {v[15:12], 4'(k), v[7:0]});
      @(negedge mclk_i);
      cmp_out(gain, {regs[0], regs[1][15:8]});
      cmp_out({19'h0, freq, en}, {19'h0, 4'(k), v[0]});
      rd_chk(6'h31, regs[2]);
    end
    rd_chk(6'h0d, regs[1]);
    rd_chk(6'h0c, regs[0]);
    rd_chk(6'h3e, crc_of());
    // mid-run reset with the host idle and chip select still tied low
    rst_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0; // reset level released and held off
    regs = '{16'h8000, 16'h0000, 16'h0000};
    repeat (4) @(negedge mclk_i);
    cmp_out(gain, 24'h800000);
    cmp_out({19'h0, freq, en}, 24'h000000);
    rd_chk(6'h3e, 16'h0000);
    wr(6'h3e, 16'($urandom));
    rd_chk(6'h3e, crc_of());
    // let the last answer reach the watcher, then no note may be left
    repeat (2) @(posedge mclk_i);
    cmp_out(24'(exp_q.size()), 24'h000000);
    end_of_test();
  end
endmodule // isolated_adc_trim_power_crc_regs_bench
`default_nettype wire
